// >>> hdl/hcm_map.vh
// Address map, codes and field positions of the host command mailbox
`ifndef HCM_MAP_VH
`define HCM_MAP_VH

// ****************************************
// APB address map
// ****************************************
`define HCM_AW 12
`define HCM_CTRL_ADDR 12'h000
`define HCM_PAGE_SEL 4'h4
`define HCM_IDX_CMD 6'h00
`define HCM_IDX_RES 6'h01
`define HCM_IDX_PRM0 6'h02
`define HCM_IDX_PRML 6'h21
`define HCM_IDX_IRQ 6'h22

// ****************************************
// Control register bits
// ****************************************
`define HCM_CTRL_POLL 0
`define HCM_CTRL_HOST_REQUEST_PENDING_BIT 1
`define HCM_CTRL_BUSY 2

// ****************************************
// Command codes
// ****************************************
`define HCM_CMD_DONE 16'h0000
`define HCM_CMD_SYNC 16'h5A5A
`define HCM_CMD_VERSION 16'h0001
`define HCM_CMD_MASK 16'h0020
`define HCM_CMD_ACK 16'h0030
`define HCM_CMD_RDHOME_A 16'h0C00
`define HCM_CMD_RDHOME_B 16'h0C01

// ****************************************
// Result codes
// ****************************************
`define HCM_RES_OK 16'h0000
`define HCM_RES_VIOL 16'h8888
`define HCM_RES_UNK 16'h8001
`define HCM_RES_RANGE 16'h8002
`define HCM_RES_EXC 16'h8003
`define HCM_RES_SPUR 16'h8007
`define HCM_RES_INV 16'h8008
`define HCM_RES_WAIT 16'h8009
`define HCM_RES_PROF 16'h800A
`define HCM_RES_FLASH 16'h800B

// ****************************************
// Event status bit positions
// ****************************************
`define HCM_EV_DONE 0
`define HCM_EV_BRK_A 1
`define HCM_EV_BRK_B 2
`define HCM_EV_TRJ_A 3
`define HCM_EV_TRJ_B 4
`define HCM_EV_HOME_A 5
`define HCM_EV_HOME_B 6
`define HCM_EV_EXC 7
`define HCM_EVW 8

// ****************************************
// Return values and reset values
// ****************************************
`define HCM_FIRM_REV 16'h0028
`define HCM_MOD_TYPE 16'h0001
`define HCM_MASK_RST 8'h00
`define HCM_FLT_LAST 3'h4

`endif

// >>> hdl/hcm_mem.v
// Parameter word store of the shared command block, registered read
`include "hcm_map.vh"

module hcm_mem (
  input wire pclk,
  input wire presetn,
  input wire we,
  input wire [4:0] addr,
  input wire [15:0] wdata,
  output reg [15:0] rdata_q
);

  reg [15:0] mem [0:31];

  always @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Read data registered so the bus mux sees a clean flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= mem[addr];
    end
  end

endmodule

// >>> hdl/hcm_home.v
// Home sensor conditioning and home event detection for both motors
`include "hcm_map.vh"

module hcm_home (
  input wire pclk,
  input wire presetn,
  input wire first_home_input,
  input wire second_home_input,
  input wire four_phase_mode,
  output wire [1:0] home_level,
  output wire [1:0] home_det
);

  wire [1:0] raw;
  wire [1:0] used;

  // [R01] Sensor to motor pairing
  assign raw = {second_home_input, first_home_input};
  // [R02] Second sensor unused in four-phase
  assign used = {~four_phase_mode, 1'b1};

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ch
      reg lvl_q;
      reg det_q;
      // [R03] Conducting emitter reads low
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lvl_q <= 1'b1;
          det_q <= 1'b0;
        end else begin
          lvl_q <= used[i] ? ~raw[i] : 1'b1;
          det_q <= used[i] & lvl_q & raw[i];
        end
      end
      assign home_level[i] = lvl_q;
      assign home_det[i] = det_q;
    end
  endgenerate

endmodule

// >>> hdl/hcm_top.v
// Host command mailbox: APB slave, command engine and event status
//
// Contract
// [R01] First sensor motor A, second motor B
// [R02] Four-phase mode ignores second sensor
// [R03] Conducting sensor reads as logic low
// [R04] Command, result, 32 params, status in page
// [R05] Host clears completion flag before command
// [R06] Host writes command word last
// [R07] Command word write starts execution
// [R08] Results written before completion flag set
// [R09] Interrupt completion chosen by mask command
// [R10] Enabled completion raises host request
// [R11] Host clears request by writing one
// [R12] Host also issues acknowledge command
// [R13] Success, violation, unknown, range result codes
// [R14] Processor fault codes 8003 to 8007
// [R15] Invalid, waiting, profile, flash result codes
// [R16] Done and breakpoint status bit values
// [R17] Trajectory, home, exception status bit values
// [R18] Status bits sticky until host clears
// [R19] Status updates regardless of mask
// [R20] Normal end clears command word
// [R21] Request bit reads line, one clears
// [R22] Mask bits match status bit positions
// [R23] Request only for unmasked events
`include "hcm_map.vh"

module hcm_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire first_home_input,
  input wire second_home_input,
  input wire four_phase_mode,
  input wire brkpt_a,
  input wire brkpt_b,
  input wire traj_a,
  input wire traj_b,
  input wire core_fault,
  input wire [2:0] core_fault_kind,
  input wire ext_wait,
  input wire profile_err,
  input wire flash_err,
  output wire host_irq,
  output wire [1:0] home_level
);

  // ****************************************
  // Engine states
  // ****************************************
  localparam ST_IDLE = 3'b000;
  localparam ST_READ = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_RET = 3'b011;
  localparam ST_WRES = 3'b100;
  localparam ST_FIN = 3'b101;

  reg [2:0] state_q;
  reg [15:0] cmd_q;
  reg [15:0] result_q;
  reg [15:0] res_pend_q;
  reg [`HCM_EVW-1:0] irqstat_q;
  reg [`HCM_EVW-1:0] mask_q;
  reg poll_q;
  reg host_request_pending_bit_q;
  reg viol_q;
  reg flt_q;
  reg [2:0] flt_kind_q;
  reg [1:0] ret_n_q;
  reg [1:0] ret_cnt_q;

  wire [15:0] mem_rdata;
  wire [1:0] home_det;
  wire busy;
  reg busy_q;

  assign busy = (state_q != ST_IDLE);

  // ****************************************
  // APB decode
  // ****************************************
  wire [5:0] idx;
  wire [5:0] prm_off;
  wire page_hit;
  wire is_ctrl;
  wire is_cmd;
  wire is_res;
  wire is_prm;
  wire is_irq;
  wire mapped;
  wire acc;
  wire wr;

  assign idx = paddr[7:2];
  assign prm_off = idx - `HCM_IDX_PRM0;
  // [R04] Command block in page four
  assign page_hit = (paddr[11:8] == `HCM_PAGE_SEL) && (paddr[1:0] == 2'b00);
  assign is_ctrl = (paddr == `HCM_CTRL_ADDR);
  assign is_cmd = page_hit && (idx == `HCM_IDX_CMD);
  assign is_res = page_hit && (idx == `HCM_IDX_RES);
  assign is_prm = page_hit && (idx >= `HCM_IDX_PRM0) && (idx <= `HCM_IDX_PRML);
  assign is_irq = page_hit && (idx == `HCM_IDX_IRQ);
  assign mapped = is_ctrl | is_cmd | is_res | is_prm | is_irq;

  // Engine owns the parameter store while busy; one more cycle refills read data
  assign pready = ~((busy | busy_q) & is_prm);
  assign pslverr = psel & penable & ~mapped;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;

  always @* begin
    prdata = 32'h00000000;
    if (is_ctrl) begin
      prdata[`HCM_CTRL_POLL] = poll_q;
      prdata[`HCM_CTRL_HOST_REQUEST_PENDING_BIT] = host_request_pending_bit_q;
      prdata[`HCM_CTRL_BUSY] = busy;
    end else if (is_cmd) begin
      prdata[15:0] = cmd_q;
    end else if (is_res) begin
      prdata[15:0] = result_q;
    end else if (is_prm) begin
      prdata[15:0] = mem_rdata;
    end else if (is_irq) begin
      prdata[`HCM_EVW-1:0] = irqstat_q;
    end
  end

  // ****************************************
  // Parameter store
  // ****************************************
  reg mem_we;
  reg [4:0] mem_addr;
  reg [15:0] mem_wdata;
  reg [15:0] ret_word;

  always @* begin
    mem_we = wr & is_prm;
    mem_addr = prm_off[4:0];
    mem_wdata = pwdata[15:0];
    if (busy) begin
      mem_addr = {3'b000, ret_cnt_q};
      mem_wdata = ret_word;
      mem_we = (state_q == ST_RET);
    end
  end

  hcm_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_q(mem_rdata)
  );

  hcm_home u_home (
    .pclk(pclk),
    .presetn(presetn),
    .first_home_input(first_home_input),
    .second_home_input(second_home_input),
    .four_phase_mode(four_phase_mode),
    .home_level(home_level),
    .home_det(home_det)
  );

  // ****************************************
  // Command decode
  // ****************************************
  reg [15:0] res_d;
  reg [1:0] ret_n_d;
  reg good;
  reg [15:0] flt_code;

  always @* begin
    res_d = `HCM_RES_OK;
    ret_n_d = 2'd0;
    // [R07] Act on the command code
    case (cmd_q)
      `HCM_CMD_SYNC: res_d = `HCM_RES_OK;
      `HCM_CMD_VERSION: ret_n_d = 2'd3;
      // [R13] Mask wider than status is out of range
      `HCM_CMD_MASK, `HCM_CMD_ACK: begin
        if (mem_rdata[15:`HCM_EVW] != 8'h00) begin
          res_d = `HCM_RES_RANGE;
        end
      end
      `HCM_CMD_RDHOME_A: ret_n_d = 2'd1;
      // [R15] Motor B home absent in four-phase
      `HCM_CMD_RDHOME_B: begin
        if (four_phase_mode) begin
          res_d = `HCM_RES_INV;
        end else begin
          ret_n_d = 2'd1;
        end
      end
      // [R13] Unrecognised command code
      default: res_d = `HCM_RES_UNK;
    endcase
    // [R15] Engine status reported on otherwise good commands
    if (res_d == `HCM_RES_OK) begin
      if (flash_err) begin
        res_d = `HCM_RES_FLASH;
      end else if (profile_err) begin
        res_d = `HCM_RES_PROF;
      end else if (ext_wait) begin
        res_d = `HCM_RES_WAIT;
      end
    end
    // [R14] Processor fault during the command
    flt_code = `HCM_RES_EXC;
    if (flt_kind_q <= `HCM_FLT_LAST) begin
      flt_code = `HCM_RES_EXC + {13'h0000, flt_kind_q};
    end
    if (flt_q) begin
      res_d = flt_code;
    end
    // [R13] Command rewritten while busy
    if (viol_q) begin
      res_d = `HCM_RES_VIOL;
    end
    good = (res_d == `HCM_RES_OK);
    if (!good) begin
      ret_n_d = 2'd0;
    end
  end

  always @* begin
    ret_word = 16'h0000;
    case (cmd_q)
      `HCM_CMD_VERSION: begin
        if (ret_cnt_q == 2'd0) begin
          ret_word = `HCM_FIRM_REV;
        end else if (ret_cnt_q == 2'd1) begin
          ret_word = `HCM_MOD_TYPE;
        end else begin
          ret_word = {15'h0000, four_phase_mode};
        end
      end
      `HCM_CMD_RDHOME_A: ret_word = {15'h0000, home_level[0]};
      `HCM_CMD_RDHOME_B: ret_word = {15'h0000, home_level[1]};
      default: ret_word = 16'h0000;
    endcase
  end

  // ****************************************
  // Command engine
  // ****************************************
  wire cmd_wr;
  assign cmd_wr = wr & is_cmd;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cmd_q <= `HCM_CMD_DONE;
      result_q <= `HCM_RES_OK;
      res_pend_q <= `HCM_RES_OK;
      viol_q <= 1'b0;
      flt_q <= 1'b0;
      flt_kind_q <= 3'h0;
      ret_n_q <= 2'd0;
      ret_cnt_q <= 2'd0;
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
      if (busy && cmd_wr) begin
        viol_q <= 1'b1;
      end
      if (busy && core_fault && !flt_q) begin
        flt_q <= 1'b1;
        flt_kind_q <= core_fault_kind;
      end
      case (state_q)
        ST_IDLE: begin
          // [R07] Command word write starts the engine
          if (cmd_wr) begin
            cmd_q <= pwdata[15:0];
            viol_q <= 1'b0;
            flt_q <= 1'b0;
            if (pwdata[15:0] != `HCM_CMD_DONE) begin
              state_q <= ST_READ;
            end
          end
        end
        ST_READ: state_q <= ST_EXEC;
        ST_EXEC: begin
          res_pend_q <= res_d;
          ret_n_q <= ret_n_d;
          ret_cnt_q <= 2'd0;
          state_q <= (ret_n_d != 2'd0) ? ST_RET : ST_WRES;
        end
        // [R08] Return words first
        ST_RET: begin
          ret_cnt_q <= ret_cnt_q + 2'd1;
          if (ret_cnt_q + 2'd1 == ret_n_q) begin
            state_q <= ST_WRES;
          end
        end
        // [R08] Result before the flag
        ST_WRES: begin
          result_q <= viol_q ? `HCM_RES_VIOL : (flt_q ? flt_code : res_pend_q);
          ret_cnt_q <= 2'd0;
          state_q <= ST_FIN;
        end
        // [R20] Clear command word on completion
        ST_FIN: begin
          cmd_q <= `HCM_CMD_DONE;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Flags, status, mask and host request
  // ****************************************
  wire fin;
  wire [`HCM_EVW-1:0] ev;
  wire [`HCM_EVW-1:0] stat_clr;
  wire do_mask;
  wire do_ack;

  assign fin = (state_q == ST_FIN);
  assign do_mask = (state_q == ST_EXEC) && good && (cmd_q == `HCM_CMD_MASK);
  assign do_ack = (state_q == ST_EXEC) && good && (cmd_q == `HCM_CMD_ACK);

  // [R16] Done and breakpoint bits
  assign ev[`HCM_EV_DONE] = fin;
  assign ev[`HCM_EV_BRK_A] = brkpt_a;
  assign ev[`HCM_EV_BRK_B] = brkpt_b;
  // [R17] Trajectory, home, exception bits
  assign ev[`HCM_EV_TRJ_A] = traj_a;
  assign ev[`HCM_EV_TRJ_B] = traj_b;
  assign ev[`HCM_EV_HOME_A] = home_det[0];
  assign ev[`HCM_EV_HOME_B] = home_det[1];
  assign ev[`HCM_EV_EXC] = core_fault;

  // Host write-one-to-clear and acknowledge command both clear
  assign stat_clr = ((wr && is_irq) ? pwdata[`HCM_EVW-1:0] : 8'h00)
                  | (do_ack ? mem_rdata[`HCM_EVW-1:0] : 8'h00);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqstat_q <= 8'h00;
      mask_q <= `HCM_MASK_RST;
      poll_q <= 1'b0;
      host_request_pending_bit_q <= 1'b0;
    end else begin
      // [R18] Sticky bits, a new event beats a clear
      // [R19] Set independent of mask
      irqstat_q <= (irqstat_q & ~stat_clr) | ev;
      // [R09] Mask set only by the mask command
      // [R22] Mask bits mirror status positions
      if (do_mask) begin
        mask_q <= mem_rdata[`HCM_EVW-1:0];
      end
      // [R08] Flag set after result is stored
      if (fin) begin
        poll_q <= 1'b1;
      end else if (wr && is_ctrl && pwdata[`HCM_CTRL_POLL]) begin
        poll_q <= 1'b0;
      end
      // [R10] [R20] [R23] Request only for enabled events
      if (|(ev & mask_q)) begin
        host_request_pending_bit_q <= 1'b1;
      end else if (wr && is_ctrl && pwdata[`HCM_CTRL_HOST_REQUEST_PENDING_BIT]) begin
        // [R21] Writing one drops the request
        host_request_pending_bit_q <= 1'b0;
      end
    end
  end

  // [R21] Line reflects the request bit
  assign host_irq = host_request_pending_bit_q;

endmodule

// >>> dv/hcm_asserts.sv
// Port checker for the host command mailbox
module hcm_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire first_home_input,
  input wire brkpt_a,
  input wire traj_b,
  input wire host_irq,
  input wire [1:0] home_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rd = acc && !pwrite && pready;
  wire prm = paddr >= 12'h408 && paddr <= 12'h484;
  wire unm = paddr != 12'h000 && paddr[11:8] != 4'h4;
  // ****************************************
  // Assertions
  // ****************************************
  property p_unm_err; acc && unm |-> pslverr; endproperty
  a_unm_err: assert property (p_unm_err) else $error("unmapped access accepted");
  property p_err_phase; pslverr |-> acc; endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_unm_zero; rd && pslverr |-> prdata == 32'h0; endproperty
  a_unm_zero: assert property (p_unm_zero) else $error("unmapped read not zero");
  property p_rdy_fast; acc && !prm |-> pready; endproperty
  a_rdy_fast: assert property (p_rdy_fast) else $error("needless wait state");
  // Parameter reads stall only while a command runs and for one cycle after
  property p_rdy_bound; acc && !pready |-> ##[1:20] pready; endproperty
  a_rdy_bound: assert property (p_rdy_bound) else $error("command never ends");
  property p_req_bit; rd && paddr == 12'h000 |-> prdata[1] == host_irq; endproperty
  a_req_bit: assert property (p_req_bit) else $error("request bit differs");
  property p_home_a; first_home_input [*4] |-> !home_level[0]; endproperty
  a_home_a: assert property (p_home_a) else $error("home level wrong");
  property p_brk; rd && paddr == 12'h488 && $past(brkpt_a) |-> prdata[1]; endproperty
  a_brk: assert property (p_brk) else $error("breakpoint bit missing");
  property p_trj; rd && paddr == 12'h488 && $past(traj_b) |-> prdata[4]; endproperty
  a_trj: assert property (p_trj) else $error("trajectory bit missing");
endmodule

bind hcm_top hcm_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .first_home_input(first_home_input), .brkpt_a(brkpt_a),
  .traj_b(traj_b), .host_irq(host_irq), .home_level(home_level));

// >>> dv/hcm_host.sv
// Host CPU model issuing mailbox commands over APB
module hcm_host (
  input wire pclk,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v,
      output logic [31:0] d, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle lines toggle so stale values never look valid
    paddr <= ~a;
    pwdata <= ~v;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic err);
    xfer(1'b0, a, 32'h0, d, err);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic err;
    xfer(1'b1, a, v, d, err);
  endtask
  task automatic wait_done;
    logic [31:0] d;
    logic err;
    do begin
      rd(12'h000, d, err);
    end while (d[0] !== 1'b1);
  endtask
  task automatic cmd(input logic [15:0] c, input logic [15:0] p0);
    wr(12'h000, 32'h1);
    wr(12'h408, {16'h0, p0});
    wr(12'h400, {16'h0, c});
    wait_done;
  endtask
  task automatic set_mask(input logic [7:0] m);
    cmd(16'h0020, {8'h0, m});
  endtask
  task automatic irq_ack(input logic [7:0] m);
    wr(12'h000, 32'h2);
    cmd(16'h0030, {8'h0, m});
  endtask
endmodule

// >>> dv/testbench.sv
// Self-checking testbench for the host command mailbox
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [4:0] evt = 5'h00;
  logic [2:0] lv = 3'h0;
  logic [2:0] fk = 3'h0;
  logic h1 = 1'b0;
  logic h2 = 1'b0;
  logic fp = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, host_irq;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [1:0] home_level;
  int error_cnt = 0;
  int compares = 0;
  logic [31:0] r;
  logic e;
  always #20 pclk = ~pclk;
  hcm_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  hcm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_home_input(h1), .second_home_input(h2),
    .four_phase_mode(fp), .brkpt_a(evt[0]), .brkpt_b(evt[1]), .traj_a(evt[2]),
    .traj_b(evt[3]), .core_fault(evt[4]), .core_fault_kind(fk), .ext_wait(lv[0]),
    .profile_err(lv[1]), .flash_err(lv[2]), .host_irq(host_irq), .home_level(home_level));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    host.rd(a, r, e);
    chk(r, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // Event lands one edge before the status read completes
  task automatic evr(input int i, input logic [31:0] exp);
    fork
      host.rd(12'h488, r, e);
      begin
        @(posedge pclk) evt[i] <= 1'b1;
        @(posedge pclk) evt[i] <= 1'b0;
      end
    join
    chk(r, exp);
  endtask
  task automatic conclude;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_map;
    rdc(12'h000, 32'h0);
    rdc(12'h400, 32'h0);
    rdc(12'h488, 32'h0);
    host.wr(12'h484, 32'h0000BEEF);
    host.wr(12'h404, 32'h0000FFFF);
    rdc(12'h484, 32'h0000BEEF);
    rdc(12'h404, 32'h0);
    host.rd(12'h100, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_poll;
    host.cmd(16'h5A5A, 16'h0);
    rdc(12'h404, 32'h0);
    rdc(12'h400, 32'h0);
    rdc(12'h000, 32'h1);
    rdc(12'h488, 32'h1);
    // Parameter read issued mid-command stalls until the returns land
    host.wr(12'h000, 32'h1);
    host.wr(12'h400, 32'h1);
    rdc(12'h408, 32'h28);
    rdc(12'h40C, 32'h1);
    rdc(12'h410, 32'h0);
  endtask
  task automatic t_errs;
    logic [15:0] cd [5] = '{16'h1234, 16'h0020, 16'h5A5A, 16'h5A5A, 16'h5A5A};
    logic [15:0] pm [5] = '{16'h0, 16'h0100, 16'h0, 16'h0, 16'h0};
    logic [2:0] ls [5] = '{3'h0, 3'h0, 3'h4, 3'h2, 3'h1};
    logic [15:0] ex [5] = '{16'h8001, 16'h8002, 16'h800B, 16'h800A, 16'h8009};
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk) lv <= ls[i];
      host.cmd(cd[i], pm[i]);
      rdc(12'h404, {16'h0, ex[i]});
    end
    @(posedge pclk) lv <= 3'h0;
    // Second command word while busy
    host.wr(12'h000, 32'h1);
    host.wr(12'h400, 32'h1);
    host.wr(12'h400, 32'h5A5A);
    host.wait_done;
    rdc(12'h404, 32'h8888);
    for (int k = 0; k < 6; k++) begin
      host.wr(12'h000, 32'h1);
      host.wr(12'h400, 32'h1);
      @(posedge pclk) evt[4] <= 1'b1;
      fk <= k[2:0];
      @(posedge pclk) evt[4] <= 1'b0;
      host.wait_done;
      rdc(12'h404, k > 4 ? 32'h8003 : 32'h8003 + k);
    end
  endtask
  task automatic t_irq;
    host.set_mask(8'h01);
    host.wr(12'h000, 32'h2);
    host.cmd(16'h5A5A, 16'h0);
    chk({31'h0, host_irq}, 32'h1);
    rdc(12'h000, 32'h3);
    host.wr(12'h000, 32'h2);
    wt(1);
    chk({31'h0, host_irq}, 32'h0);
    host.set_mask(8'h02);
    host.wr(12'h000, 32'h2);
    host.wr(12'h488, 32'hFF);
    evr(0, 32'h02);
    wt(1);
    chk({31'h0, host_irq}, 32'h1);
    host.wr(12'h000, 32'h2);
    evr(1, 32'h06);
    wt(1);
    chk({31'h0, host_irq}, 32'h0);
    evr(2, 32'h0E);
    evr(3, 32'h1E);
    evr(4, 32'h9E);
    wt(20);
    rdc(12'h488, 32'h9E);
    host.irq_ack(8'h9E);
    rdc(12'h488, 32'h01);
  endtask
  task automatic t_home;
    host.wr(12'h488, 32'hFF);
    @(posedge pclk) h1 <= 1'b1;
    wt(4);
    chk({30'h0, home_level}, 32'h2);
    rdc(12'h488, 32'h20);
    @(posedge pclk) h2 <= 1'b1;
    wt(4);
    rdc(12'h488, 32'h60);
    host.cmd(16'h0C00, 16'h0);
    rdc(12'h408, 32'h0);
    @(posedge pclk) h2 <= 1'b0;
    fp <= 1'b1;
    wt(4);
    host.wr(12'h488, 32'hFF);
    @(posedge pclk) h2 <= 1'b1;
    wt(4);
    rdc(12'h488, 32'h0);
    host.cmd(16'h0C01, 16'h0);
    rdc(12'h404, 32'h8008);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_map;
    t_poll;
    t_errs;
    t_irq;
    t_home;
    conclude;
  end
  // Far above the few hundred cycles the scenarios need
  initial begin
    #(40 * 40000);
    error_cnt++;
    conclude;
  end
endmodule
